// file: wsw_consts.svh
/*
  constants of the watchdog and sleep/wake block: fuse layout, fuse modes,
  register map, flag reset values and delay counts.
  assumes it is included once per compile unit by its bare name.
*/
`ifndef WSW_CONSTS_SVH
`define WSW_CONSTS_SVH

// fuse locations in program memory
`define WSW_FUSE_ADDR_WDT_LO 16'hfe02
`define WSW_FUSE_ADDR_WDT_HI 16'hfe03

// bit positions in the fuse byte read from fe00..fe07
`define WSW_FUSE_OSC_LO 0
`define WSW_FUSE_OSC_HI 1
`define WSW_FUSE_WDT_LO 2
`define WSW_FUSE_WDT_HI 3

// watchdog fuse codes {hi,lo}
`define WSW_WDT_P256  2'b10
`define WSW_WDT_P64   2'b01
`define WSW_WDT_P1    2'b11
`define WSW_WDT_TIMER 2'b00

// oscillator fuse codes {hi,lo}
`define WSW_OSC_LOWFREQ 2'b00
`define WSW_OSC_RC      2'b01
`define WSW_OSC_CRYSTAL 2'b10
`define WSW_OSC_EC      2'b11

// prescaler terminal counts (prescale minus one)
`define WSW_PRE_TOP_256 8'hff
`define WSW_PRE_TOP_64  8'h3f
`define WSW_PRE_TOP_1   8'h00

// start-up delay in oscillator periods
`define WSW_STARTUP_PERIODS 1024

// register byte offsets
`define WSW_REG_STATUS 8'h00
`define WSW_REG_EVENT  8'h04
`define WSW_REG_MASK   8'h08

// status register fields
`define WSW_ST_TIMEOUT 0
`define WSW_ST_PWRDN   1
`define WSW_ST_WDT   2
`define WSW_ST_OSC   4
`define WSW_ST_SLEEP 6

// event register fields
`define WSW_EV_OVF   0
`define WSW_EV_WAKE  1
`define WSW_EV_RESET 2
`define WSW_EV_TIMER 3
`define WSW_EV_W     4

// reset values
`define WSW_TIMEOUT_RST 1'b1
`define WSW_PWRDN_RST   1'b1
`define WSW_MASK_RST 4'h0

`endif

// file: wsw_pkg.sv
/*
  types of the watchdog and sleep/wake block.
  assumes nothing of its surroundings.
*/
package wsw_pkg;

  typedef enum logic [2:0] {
    WSW_PWRUP,
    WSW_STARTUP,
    WSW_RUN,
    WSW_SLEEP,
    WSW_MASTER_CLR
  } wsw_state_t;

endpackage : wsw_pkg

// file: wsw_watchdog.sv
/*
  watchdog, power-up/start-up delay and sleep/wake control of an 8-bit core,
  with an apb register slave and one interrupt output.
  assumes: the core gives one-cycle strobes on pclk for instruction ticks,
  oscillator ticks, clear-watchdog, sleep fetch and sleep execute; the rc
  oscillator and the master clear pin arrive asynchronously; fuse_byte is
  the fe00..fe07 fuse read value, stable after reset.
*/
// The implementer's own choices: the register addresses and register access over APB.
//
// Contract
// - 8-bit counter behind 8-bit prescaler, rc clocked
// - watchdog count never visible to software
// - fuses 01/11/10 give rc prescale 64/1/256
// - fuses 00 use instruction clock, prescale 256
// - timer mode overflows after 65536 cycles
// - fuse bits from fe03h and fe02h
// - clear, sleep, power-on clear count, set timeout
// - rc mode overflow resets the chip; in sleep the code wakes and resumes at n+1 instead
// - timer overflow clears timeout flag, no reset
// - timer mode halts during sleep
// - same counter serves as power-up timer
// - interrupt at sleep fetch makes sleep nop
// - program counter zero after resets and timeout; a timeout in sleep resumes at n+1 instead
// - sleep stops oscillator, clears power-down flag
// - interrupt wake runs n+1 then vector/continue
// - start-up delay only in crystal modes
// - start-up delay holds core 1024 periods
// - disabled interrupts wake without vectoring
`timescale 1ns/1ps
`include "wsw_consts.svh"

module wsw_watchdog
  import wsw_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        wdt_rc_osc,
  input  wire logic        master_clear_pin_n,
  input  wire logic [7:0]  fuse_byte,
  input  wire logic        instr_tick,
  input  wire logic        osc_tick,
  input  wire logic        clear_watchdog_instr,
  input  wire logic        sleep_fetch,
  input  wire logic        sleep_exec,
  input  wire logic        irq_wake_req,
  input  wire logic        global_irq_disable,
  output logic             core_reset,
  output logic             osc_enable,
  output logic             pc_zero_load,
  output logic             resume_next,
  output logic             wake_vector,
  output logic             timeout_flag,
  output logic             powerdown_flag,
  output logic             irq
);

  localparam logic [7:0] STARTUP_CNT_LAST = 8'(`WSW_STARTUP_PERIODS / 256 - 1);

  wsw_state_t  state_r;
  wsw_state_t  state_nxt;
  logic        rc_s1_r, rc_s2_r, rc_s3_r, rc_lvl_r;
  logic        mc_s1_r, mc_s2_r, mc_s3_r, mc_lvl_r;
  logic        rc_rise;
  logic        mclear_act;
  logic        fuse_ok_r;
  logic [1:0]  wdt_mode_r;
  logic [1:0]  osc_mode_r;
  logic        crystal;
  logic        rc_mode;
  logic [7:0]  pre_r;
  logic [7:0]  cnt_r;
  logic [7:0]  pre_top;
  logic        tick;
  logic        wrap;
  logic        clr_cnt;
  logic        cwdt_go;
  logic        sleep_go;
  logic        irq_fetch_r;
  logic        ovf;
  logic        wake_irq;
  logic        leave_hold;
  logic        wake_go;
  logic        resume_sel;
  logic        vec_sel;
  logic        resume_n1_r;
  logic        vec_pend_r;
  logic        was_sleep_r;
  logic        wdt_rst_r;
  logic [3:0]  evt_r;
  logic [3:0]  evt_set;
  logic [3:0]  mask_r;
  logic [31:0] rd_mux;
  logic        hit;
  logic        rd_evt;

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers: a change counts once the 2nd and 3rd flops agree

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rc_s1_r  <= 1'b0;
      rc_s2_r  <= 1'b0;
      rc_s3_r  <= 1'b0;
      rc_lvl_r <= 1'b0;
    end else begin
      rc_s1_r <= wdt_rc_osc;
      rc_s2_r <= rc_s1_r;
      rc_s3_r <= rc_s2_r;
      if (rc_s2_r == rc_s3_r) begin
        rc_lvl_r <= rc_s3_r;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mc_s1_r  <= 1'b1;
      mc_s2_r  <= 1'b1;
      mc_s3_r  <= 1'b1;
      mc_lvl_r <= 1'b1;
    end else begin
      mc_s1_r <= master_clear_pin_n;
      mc_s2_r <= mc_s1_r;
      mc_s3_r <= mc_s2_r;
      if (mc_s2_r == mc_s3_r) begin
        mc_lvl_r <= mc_s3_r;
      end
    end
  end

  assign rc_rise  = (rc_s2_r == rc_s3_r) & rc_s3_r & ~rc_lvl_r;
  assign mclear_act = ~mc_lvl_r;

  //////////////////////////////////////////////////////////////////////////
  // fuses are caught on the first edge after reset release

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fuse_ok_r  <= 1'b0;
      wdt_mode_r <= `WSW_WDT_P256;
      osc_mode_r <= `WSW_OSC_RC;
    end else if (!fuse_ok_r) begin
      fuse_ok_r <= 1'b1;
      wdt_mode_r <= {fuse_byte[`WSW_FUSE_WDT_HI], fuse_byte[`WSW_FUSE_WDT_LO]};
      osc_mode_r <= {fuse_byte[`WSW_FUSE_OSC_HI], fuse_byte[`WSW_FUSE_OSC_LO]};
    end
  end

  assign crystal = (osc_mode_r == `WSW_OSC_LOWFREQ) | (osc_mode_r == `WSW_OSC_CRYSTAL);
  assign rc_mode = wdt_mode_r != `WSW_WDT_TIMER;

  //////////////////////////////////////////////////////////////////////////
  // shared prescaler and counter

  always_comb begin
    pre_top = `WSW_PRE_TOP_256;
    tick    = 1'b0;
    case (state_r)
      WSW_PWRUP: begin
        pre_top = `WSW_PRE_TOP_1;
        tick    = rc_rise;
      end
      WSW_STARTUP: begin
        tick = osc_tick;
      end
      WSW_RUN, WSW_SLEEP: begin
        case (wdt_mode_r)
          `WSW_WDT_P64: pre_top = `WSW_PRE_TOP_64;
          `WSW_WDT_P1:  pre_top = `WSW_PRE_TOP_1;
          default:      pre_top = `WSW_PRE_TOP_256;
        endcase
        if (rc_mode) begin
          tick = rc_rise;
        end else begin
          tick = instr_tick & (state_r == WSW_RUN);
        end
      end
      default: begin
        tick = 1'b0;
      end
    endcase
  end

  assign wrap = tick & (pre_r == pre_top);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_fetch_r <= 1'b0;
    end else begin
      irq_fetch_r <= sleep_fetch & irq_wake_req;
    end
  end

  assign cwdt_go  = clear_watchdog_instr & (state_r == WSW_RUN);
  assign sleep_go = sleep_exec & (state_r == WSW_RUN) & ~irq_fetch_r;
  assign ovf      = wrap & (cnt_r == 8'hff) & ~cwdt_go
                  & ((state_r == WSW_RUN) | (state_r == WSW_SLEEP));
  assign wake_irq = irq_wake_req & (state_r == WSW_SLEEP);
  assign clr_cnt  = cwdt_go | sleep_go | (state_nxt != state_r) | (ovf & rc_mode);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_r <= 8'h00;
      cnt_r <= 8'h00;
    end else if (clr_cnt) begin
      pre_r <= 8'h00;
      cnt_r <= 8'h00;
    end else if (wrap) begin
      pre_r <= 8'h00;
      cnt_r <= cnt_r + 8'h01;
    end else if (tick) begin
      pre_r <= pre_r + 8'h01;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // state sequence

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      WSW_PWRUP: begin
        if (wrap & (cnt_r == 8'hff)) begin
          state_nxt = crystal ? WSW_STARTUP : WSW_RUN;
        end
      end
      WSW_STARTUP: begin
        if (wrap & (cnt_r == STARTUP_CNT_LAST)) begin
          state_nxt = WSW_RUN;
        end
      end
      WSW_RUN: begin
        if (sleep_go) begin
          state_nxt = WSW_SLEEP;
        end
      end
      WSW_SLEEP: begin
        if (ovf | wake_irq) begin
          state_nxt = crystal ? WSW_STARTUP : WSW_RUN;
        end
      end
      WSW_MASTER_CLR: begin
        if (!mclear_act) begin
          state_nxt = (was_sleep_r & crystal) ? WSW_STARTUP : WSW_RUN;
        end
      end
      default: begin
        state_nxt = WSW_PWRUP;
      end
    endcase
    if (mclear_act & (state_r != WSW_PWRUP)) begin
      state_nxt = WSW_MASTER_CLR;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= WSW_PWRUP;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign leave_hold = (state_r != WSW_RUN) & (state_nxt == WSW_RUN);
  // a wake straight into run leaves in the very edge that records it
  assign wake_go    = (state_r == WSW_SLEEP) & (ovf | wake_irq) & ~mclear_act;
  assign resume_sel = resume_n1_r | wake_go;
  assign vec_sel    = wake_go ? (wake_irq & ~global_irq_disable) : vec_pend_r;

  // how execution resumes once the hold ends
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resume_n1_r <= 1'b0;
      vec_pend_r  <= 1'b0;
      was_sleep_r <= 1'b0;
    end else begin
      if (wake_go) begin
        resume_n1_r <= 1'b1;
        vec_pend_r  <= wake_irq & ~global_irq_disable;
      end else if (state_nxt == WSW_MASTER_CLR) begin
        resume_n1_r <= 1'b0;
        vec_pend_r  <= 1'b0;
      end
      if ((state_nxt == WSW_MASTER_CLR) & (state_r != WSW_MASTER_CLR)) begin
        was_sleep_r <= state_r == WSW_SLEEP;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // core-facing outputs

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_rst_r    <= 1'b0;
      pc_zero_load <= 1'b0;
      resume_next  <= 1'b0;
      wake_vector  <= 1'b0;
    end else begin
      wdt_rst_r    <= ovf & rc_mode & (state_r == WSW_RUN);
      pc_zero_load <= (leave_hold & ~resume_sel)
                    | (ovf & rc_mode & (state_r == WSW_RUN));
      resume_next  <= leave_hold & resume_sel;
      wake_vector  <= leave_hold & resume_sel & vec_sel;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_reset <= 1'b1;
      osc_enable <= 1'b1;
    end else begin
      core_reset <= (state_nxt == WSW_PWRUP) | (state_nxt == WSW_STARTUP)
                  | (state_nxt == WSW_MASTER_CLR) | (ovf & rc_mode & (state_r == WSW_RUN));
      osc_enable <= state_nxt != WSW_SLEEP;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timeout_flag <= `WSW_TIMEOUT_RST;
    end else if (cwdt_go | sleep_go) begin
      timeout_flag <= 1'b1;
    end else if (ovf) begin
      timeout_flag <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      powerdown_flag <= `WSW_PWRDN_RST;
    end else if (sleep_go) begin
      powerdown_flag <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // apb slave; events are sticky, cleared by reading them

  assign hit = (paddr == `WSW_REG_STATUS) | (paddr == `WSW_REG_EVENT)
             | (paddr == `WSW_REG_MASK);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign rd_evt  = psel & penable & ~pwrite & (paddr == `WSW_REG_EVENT);

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      `WSW_REG_STATUS: begin
        rd_mux[`WSW_ST_TIMEOUT]   = timeout_flag;
        rd_mux[`WSW_ST_PWRDN]     = powerdown_flag;
        rd_mux[`WSW_ST_WDT +: 2]  = wdt_mode_r;
        rd_mux[`WSW_ST_OSC +: 2]  = osc_mode_r;
        rd_mux[`WSW_ST_SLEEP]     = state_r == WSW_SLEEP;
      end
      `WSW_REG_EVENT: rd_mux[`WSW_EV_W-1:0] = evt_r;
      `WSW_REG_MASK:  rd_mux[`WSW_EV_W-1:0] = mask_r;
      default:        rd_mux = 32'h0000_0000;
    endcase
  end

  // read data taken in the setup cycle so it comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel & ~penable & ~pwrite) begin
      prdata <= rd_mux;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_r <= `WSW_MASK_RST;
    end else if (psel & penable & pwrite & (paddr == `WSW_REG_MASK)) begin
      mask_r <= pwdata[`WSW_EV_W-1:0];
    end
  end

  always_comb begin
    evt_set                = 4'h0;
    evt_set[`WSW_EV_OVF]   = ovf & rc_mode;
    evt_set[`WSW_EV_WAKE]  = leave_hold & resume_sel;
    evt_set[`WSW_EV_RESET] = ovf & rc_mode & (state_r == WSW_RUN);
    evt_set[`WSW_EV_TIMER] = ovf & ~rc_mode;
  end

  // only bits actually returned are cleared; a new event wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_r <= 4'h0;
    end else begin
      evt_r <= (evt_r & ~(rd_evt ? prdata[`WSW_EV_W-1:0] : 4'h0)) | evt_set;
    end
  end

  assign irq = |(evt_r & mask_r);

endmodule : wsw_watchdog

// file: wsw_props.sv
/*
  port checker of the watchdog block.
  assumes it is bound to wsw_watchdog and sees its ports only.
*/
`timescale 1ns/1ps
module wsw_props (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic [7:0] paddr,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       clear_watchdog_instr,
  input wire logic       sleep_fetch,
  input wire logic       sleep_exec,
  input wire logic       irq_wake_req,
  input wire logic       core_reset,
  input wire logic       osc_enable,
  input wire logic       resume_next,
  input wire logic       wake_vector,
  input wire logic       timeout_flag,
  input wire logic       powerdown_flag
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////
  a_zero_wait: assert property (pready) else $error("pready low");
  a_unmapped_err: assert property (psel && penable && !(paddr inside {8'h00, 8'h04, 8'h08}) |-> pslverr)
    else $error("no error on unmapped access");
  a_clear_sets_timeout: assert property (clear_watchdog_instr && !core_reset && osc_enable |=> timeout_flag)
    else $error("clear did not set timeout");
  a_timeout_cause: assert property ($rose(timeout_flag) |-> $past(clear_watchdog_instr) || $past(sleep_exec))
    else $error("timeout rose without cause");
  a_sleep_enter: assert property (sleep_fetch && !irq_wake_req && !core_reset && osc_enable ##1 sleep_exec
    |=> !powerdown_flag && !osc_enable) else $error("sleep not entered");
  a_sleep_nop: assert property (sleep_fetch && irq_wake_req && osc_enable ##1 sleep_exec
    |=> osc_enable && $stable(powerdown_flag)) else $error("sleep not a nop");
  a_pd_no_rise: assert property (!$rose(powerdown_flag)) else $error("powerdown rose");
  a_osc_off_pwrdn: assert property (!osc_enable |-> !powerdown_flag) else $error("asleep with powerdown set");
  a_vector_pair: assert property (wake_vector |-> resume_next) else $error("vector alone");
  a_resume_pulse: assert property (resume_next |=> !resume_next) else $error("resume too long");
endmodule : wsw_props

bind wsw_watchdog wsw_props u_props (.*);

// file: testbench.sv
/*
  self-checking bench of the watchdog block.
  assumes wsw_watchdog, its header and the bound checker.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fails++; $display("Error %0t: mismatch", $time); end end
module testbench;
  import wsw_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0]  paddr, fuse_byte;
  logic [31:0] pwdata, prdata, r;
  logic        wdt_rc_osc = 0, master_clear_pin_n, instr_tick, osc_tick, clear_watchdog_instr;
  logic        sleep_fetch, sleep_exec, irq_wake_req, global_irq_disable, core_reset, osc_enable;
  logic        pc_zero_load, resume_next, wake_vector, timeout_flag, powerdown_flag, irq;
  logic [1:0]  rc_div = 0;
  int          fails, n_checks, cyc, seed, m, c_rc, c_cry;
  logic        exp_tmo, exp_pwrdn;
  wsw_watchdog u_dut (.*);
  initial begin
    pclk = 0;
    forever #2.5 pclk = ~pclk;
  end
  // rc oscillator unrelated to the core: one tick per 4 cycles
  always @(posedge pclk) begin
    rc_div <= rc_div + 2'h1;
    wdt_rc_osc <= rc_div[1];
    cyc++;
    if (cyc == 90000) begin
      fails++;
      end_of_test();
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  task automatic step(input int n);
    repeat (n) @(posedge pclk);
  endtask : step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0; penable <= 0;
    // one idle edge so a following call never reassigns psel in this time step
    @(posedge pclk);
  endtask : apb
  function automatic logic [31:0] status(input logic [7:0] f);
    return {26'h0, f[1:0], f[3:2], exp_pwrdn, exp_tmo};
  endfunction : status
  task automatic do_reset(input logic [7:0] f, output int c);
    presetn <= 0; fuse_byte <= f; step(20); presetn <= 1;
    exp_tmo = 1; exp_pwrdn = 1; c = 0;
    do begin @(posedge pclk); c++; end while (core_reset !== 1'b0);
  endtask : do_reset
  task automatic do_sleep(input logic i);
    irq_wake_req <= i; sleep_fetch <= 1; step(1);
    sleep_fetch <= 0; sleep_exec <= 1; step(1);
    sleep_exec <= 0; irq_wake_req <= 0; step(2);
    if (!i) begin exp_pwrdn = 0; exp_tmo = 1; end
    `CHK({powerdown_flag, osc_enable}, {exp_pwrdn, i})
  endtask : do_sleep
  task automatic wait_resume;
    do @(posedge pclk); while (resume_next !== 1'b1);
  endtask : wait_resume
  ////////////////////////////////////////////////////////////
  initial begin
    {presetn, psel, penable, pwrite, instr_tick, osc_tick, clear_watchdog_instr} = 0;
    {sleep_fetch, sleep_exec, irq_wake_req, global_irq_disable} = 0;
    paddr = 0; pwdata = 0; fuse_byte = 0; master_clear_pin_n = 1; seed = 73;
    do_reset(8'h01, c_rc);
    apb(0, 8'h00, 0); `CHK(r, status(8'h01))
    apb(1, 8'h00, 32'hff); apb(0, 8'h00, 0); `CHK(r, status(8'h01))
    apb(0, 8'h0c, 0); `CHK({e, r}, 33'h1_0000_0000)
    m = $random(seed) & 15; apb(1, 8'h08, 32'(m) | 32'hff0); apb(0, 8'h08, 0); `CHK(r, 32'(m))
    apb(1, 8'h08, 0);
    $display("test registers done");
    clear_watchdog_instr <= 1; step(1); clear_watchdog_instr <= 0;
    instr_tick <= 1; step(65535); instr_tick <= 0; step(2);
    `CHK(timeout_flag, 1'b1)
    instr_tick <= 1; step(1); instr_tick <= 0; step(2);
    `CHK({timeout_flag, core_reset, irq}, 3'b000)
    apb(1, 8'h08, 32'h8); step(2); `CHK(irq, 1'b1)
    apb(0, 8'h04, 0); step(2); `CHK({r, irq}, 33'h10)
    clear_watchdog_instr <= 1; step(1); clear_watchdog_instr <= 0; step(1);
    `CHK(timeout_flag, 1'b1)
    $display("test timer mode done");
    do_sleep(1);
    for (int g = 0; g < 2; g++) begin
      global_irq_disable <= g[0];
      do_sleep(0);
      irq_wake_req <= 1;
      wait_resume();
      `CHK(wake_vector, ~g[0])
      irq_wake_req <= 0; step(2);
      apb(0, 8'h00, 0); `CHK(r, status(8'h01))
    end
    $display("test sleep done");
    global_irq_disable <= 0;
    do_reset(8'h0d, c_rc);
    step(4);
    do @(posedge pclk); while (pc_zero_load !== 1'b1);
    `CHK(core_reset, 1'b1)
    step(2); apb(0, 8'h04, 0); `CHK({r, timeout_flag}, 33'ha)
    do_sleep(0);
    wait_resume();
    `CHK({wake_vector, timeout_flag}, 2'b00)
    step(2); apb(0, 8'h04, 0); `CHK(r, 32'h3)
    $display("test rc watchdog done");
    osc_tick <= 1;
    do_reset(8'h0e, c_cry);
    `CHK((c_cry - c_rc) inside {[1020:1030]}, 1'b1)
    master_clear_pin_n <= 0; step(8);
    `CHK({core_reset, osc_enable}, 2'b11)
    master_clear_pin_n <= 1;
    do @(posedge pclk); while (pc_zero_load !== 1'b1);
    `CHK({core_reset, resume_next, timeout_flag}, 3'b001)
    $display("test start-up delay done");
    end_of_test();
  end
endmodule : testbench
